// ---- common/clkdiv_pkg.sv ----
// Package: register map, field positions, reset values and timing for the divider control
package clkdiv_pkg;
  // Serial frame: 32 bits, data in [31:4], register address in [3:0]
  localparam int FRAME_BITS = 32;
  localparam logic [3:0] ADDR_SYNC_CTRL = 4'h3;
  localparam logic [3:0] ADDR_PAIR_DLY = 4'h4;
  localparam logic [3:0] ADDR_DIV_SEL = 4'h5;
  localparam logic [3:0] ADDR_LOCK = 4'hF;
  localparam logic [3:0] ADDR_LOCK_LIMIT = 4'h5;
  // Field positions in sync_and_delay_control
  localparam int POS_HALF_SHIFT = 10;
  localparam int POS_QUALIFY = 11;
  localparam int POS_POL_A = 14;
  localparam int POS_POL_B = 15;
  localparam int POS_MASK_LO = 16;
  localparam int POS_FAST_B = 24;
  localparam int POS_AUTO_A = 25;
  localparam int POS_AUTO_B = 26;
  // Field positions in pair_digital_delay
  localparam int POS_DDLY_LO = 4;
  // Field positions in divider_and_delay_select
  localparam int POS_DIV0_LO = 4;
  localparam int POS_DIV1_LO = 7;
  localparam int POS_DIV2_LO = 10;
  localparam int POS_ADLY12 = 13;
  localparam int POS_ADLY13 = 14;
  localparam int POS_PDIV_LO = 17;
  // Field position in write_lock_control
  localparam int POS_LOCK = 4;
  // Reset values
  localparam logic [31:0] RST_SYNC_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_PAIR_DLY = 32'h0000_0000;
  localparam logic [31:0] RST_DIV_SEL = 32'h0002_0000;
  localparam logic [31:0] RST_LOCK = 32'h0000_0000;
  // Delay and divide thresholds
  localparam logic [9:0] DDLY_MIN_CODE = 10'h005;
  localparam logic [9:0] DDLY_EXT_CODE = 10'h00D;
  localparam logic [10:0] PDIV_EXT_CODE = 11'h01A;
  localparam logic [10:0] PDIV_MAX_CODE = 11'h415;
  localparam logic [1:0] QUAL_ENABLED = 2'h3;
endpackage

// ---- hw/sync_stage.sv ----
// Three-stage synchroniser with agreement filter on the last two stages
`timescale 1ns/10ps
module sync_stage (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  // Shift chain; only stage two and three are compared
  typedef struct packed {
    logic [2:0] chain;
    logic level;
  } state_t;
  state_t cur;
  state_t next_cur;

  // Next state: shift and update level when stages agree
  always_comb begin
    next_cur = cur;
    next_cur.chain = {cur.chain[1:0], din};
    if (cur.chain[2] == cur.chain[1]) begin
      next_cur.level = cur.chain[2];
    end
  end

  // Register update
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign dout = cur.level;
endmodule

// ---- hw/out_divider.sv ----
// Output divider with 50 percent duty for odd and even values and sync hold
`timescale 1ns/10ps
module out_divider #(
  parameter int W = 11
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic [W-1:0] divide,
  input wire logic hold,
  input wire logic [W-1:0] startDelay,
  input wire logic halfShift,
  output logic clkOut
);
  // Counts input ticks; phase output toggles at half points
  typedef struct packed {
    logic [W-1:0] count;
    logic [W-1:0] delayLeft;
    logic delaying;
    logic phase;
    logic held;
  } state_t;
  state_t cur;
  state_t next_cur;

  // Next state: hold low on sync, wait delay, then run
  always_comb begin
    next_cur = cur;
    if (hold) begin
      next_cur.count = '0;
      next_cur.phase = 1'b0;
      next_cur.held = 1'b1;
      next_cur.delayLeft = startDelay;
      next_cur.delaying = 1'b1;
    end else if (tick) begin
      next_cur.held = 1'b0;
      if (cur.delaying) begin
        // Half shift trims one tick, half an input period, from the start wait at once
        if (cur.delayLeft <= W'(halfShift) + W'(1)) begin
          next_cur.delaying = 1'b0;
        end else begin
          next_cur.delayLeft = cur.delayLeft - W'(1);
        end
      end else if (cur.count >= divide - W'(1)) begin
        // Ticks are input half periods, so toggling every divide ticks gives 50 percent
        next_cur.count = '0;
        next_cur.phase = ~cur.phase;
      end else begin
        next_cur.count = cur.count + W'(1);
      end
    end
  end

  // Register update
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign clkOut = cur.phase & ~cur.held;
endmodule

// ---- hw/clock_divider_sync_control.sv ----
// Serial-programmed divider, delay, sync and lock control for both output banks
`timescale 1ns/10ps
// Function
// - Half shift trims half period
// - Half shift acts immediately, no power change
// - Qualify code 3 syncs bank B; qualCode reads bit 11 twice, so bit 11 alone enables it
// - Qualified pulse fixed to output phase
// - Only pair 12-13 gets digital delay
// - Polarity bit chooses sync level, outputs low
// - Polarity toggle acts as sync edge
// - Mask bit keeps group running
// - Masked groups unaffected by sync
// - Masking keeps earlier alignment
// - Auto sync on delay/divider load
// - Internal sync at strobe fall
// - Delay applied only on unmasked sync
// - Delay cycles per code and divide
// - Delay code 13+ extended mode
// - Analog delay select and powerdown
// - Group divide code, zero is eight
// - Dividers give 50 percent duty
// - Pair divide 1-1045, 26+ extended; codes above 1045 are not clamped, 0 divides by 1
// - Lock blocks writes to 0-5
module clock_divider_sync_control (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic serialClock,
  input wire logic serialData,
  input wire logic serial_load_strobe,
  input wire logic bank_a_sync_pin,
  input wire logic bank_b_sync_pin,
  input wire logic bank_a_input_clock,
  input wire logic bank_b_input_clock,
  output logic [11:0] bankAOut,
  output logic [1:0] pairOut,
  output logic pairExtendedMode,
  output logic analogDelayPower,
  output logic [1:0] analogDelayRoute,
  output logic [9:0] pairDelayCycles,
  output logic registersLocked
);
  // Control state in one struct, apart from the input clock edge registers clkAPrev and clkBPrev
  typedef struct packed {
    logic [31:0] frame;
    logic [31:0] syncCtrl;
    logic [31:0] pairDly;
    logic [31:0] divSel;
    logic [31:0] lockReg;
    logic sclkPrev;
    logic strobePrev;
    logic [1:0] polPrev;
    logic [1:0] pinPrev;
    logic pendA;
    logic pendB;
    logic [1:0] bankHold;
    logic pairQualWait;
    logic [9:0] appliedDelay;
    logic [3:0] aligned;
  } state_t;
  state_t cur;
  state_t next_cur;

  // Synchronised pin levels
  logic sclkS;
  logic dataS;
  logic strobeS;
  logic syncPinA;
  logic syncPinB;
  logic clkAS;
  logic clkBS;
  logic clkAPrev;
  logic clkBPrev;
  logic tickA;
  logic tickB;
  logic [3:0] mask;
  logic [1:0] polInv;
  logic [1:0] pinActive;
  logic [1:0] syncEdge;
  logic loadDone;
  logic [3:0] frameAddr;
  logic [27:0] frameData;
  logic writeOk;
  logic [1:0] qualCode;
  logic qualOn;
  logic [3:0] groupHold;
  logic [2:0] grpDiv [3];
  logic [10:0] pairDiv;
  logic [9:0] ddlyCode;
  logic [9:0] ddlyCycles;

  // Pin synchronisers, one per asynchronous input
  sync_stage u_sclk (.core_clk(core_clk), .rst(rst), .din(serialClock), .dout(sclkS));
  sync_stage u_data (.core_clk(core_clk), .rst(rst), .din(serialData), .dout(dataS));
  sync_stage u_le (.core_clk(core_clk), .rst(rst), .din(serial_load_strobe), .dout(strobeS));
  sync_stage u_spa (.core_clk(core_clk), .rst(rst), .din(bank_a_sync_pin), .dout(syncPinA));
  sync_stage u_spb (.core_clk(core_clk), .rst(rst), .din(bank_b_sync_pin), .dout(syncPinB));
  sync_stage u_cka (.core_clk(core_clk), .rst(rst), .din(bank_a_input_clock), .dout(clkAS));
  sync_stage u_ckb (.core_clk(core_clk), .rst(rst), .din(bank_b_input_clock), .dout(clkBS));

  // Input clock edges serve as divider ticks
  always_ff @(posedge core_clk) begin
    if (rst) begin
      clkAPrev <= 1'b0;
      clkBPrev <= 1'b0;
    end else begin
      clkAPrev <= clkAS;
      clkBPrev <= clkBS;
    end
  end
  // Both input edges tick, so odd divides keep a 50 percent duty
  assign tickA = clkAS ^ clkAPrev;
  assign tickB = clkBS ^ clkBPrev;

  // Field extraction
  assign mask = cur.syncCtrl[clkdiv_pkg::POS_MASK_LO +: 4];
  assign polInv = {cur.syncCtrl[clkdiv_pkg::POS_POL_B], cur.syncCtrl[clkdiv_pkg::POS_POL_A]};
  assign qualCode = {cur.syncCtrl[clkdiv_pkg::POS_QUALIFY], cur.syncCtrl[clkdiv_pkg::POS_QUALIFY]};
  assign qualOn = (qualCode == clkdiv_pkg::QUAL_ENABLED);
  assign pairDiv = cur.divSel[clkdiv_pkg::POS_PDIV_LO +: 11];
  assign ddlyCode = cur.pairDly[clkdiv_pkg::POS_DDLY_LO +: 10];
  assign frameAddr = cur.frame[3:0];
  assign frameData = cur.frame[31:4];
  assign loadDone = cur.strobePrev & ~strobeS;
  // Lock bit stops writes to addresses 0 to 5
  assign writeOk = ~(cur.lockReg[clkdiv_pkg::POS_LOCK] && frameAddr <= clkdiv_pkg::ADDR_LOCK_LIMIT);

  // Sync level per bank, inverted by polarity bit
  assign pinActive = {syncPinB ^ polInv[1], syncPinA ^ polInv[0]};
  // Rising active level, either from the pin or a polarity toggle
  assign syncEdge = pinActive & ~cur.pinPrev;

  // Delay cycles: 5 or 6 below code 6, code or code+1 above
  always_comb begin
    if (ddlyCode <= clkdiv_pkg::DDLY_MIN_CODE) begin
      ddlyCycles = clkdiv_pkg::DDLY_MIN_CODE + ((pairDiv > 11'h001) ? 10'h001 : 10'h000);
    end else begin
      ddlyCycles = ddlyCode + ((pairDiv > 11'h001) ? 10'h001 : 10'h000);
    end
  end

  // Next state: serial shift, register load, sync generation
  always_comb begin
    next_cur = cur;
    next_cur.sclkPrev = sclkS;
    next_cur.strobePrev = strobeS;
    next_cur.polPrev = polInv;
    next_cur.pinPrev = pinActive;
    // Consume pending syncs first, so a new request in the same cycle wins
    if (cur.pendA) begin
      next_cur.pendA = 1'b0;
    end
    // Qualified bank B release waits for output 12 low phase
    if (cur.pendB) begin
      if (!qualOn || !pairOut[0]) begin
        next_cur.pendB = 1'b0;
        next_cur.pairQualWait = 1'b0;
        // Delay latched only when pair is unmasked
        if (!mask[3]) begin
          next_cur.appliedDelay = ddlyCycles;
        end
      end else begin
        next_cur.pairQualWait = 1'b1;
      end
    end
    // Shift in on serial clock rising edge, MSB first
    if (sclkS && !cur.sclkPrev) begin
      next_cur.frame = {cur.frame[30:0], dataS};
    end
    // Register load on strobe fall
    if (loadDone && writeOk) begin
      case (frameAddr)
        clkdiv_pkg::ADDR_SYNC_CTRL: begin
          next_cur.syncCtrl = {frameData, 4'h0};
        end
        clkdiv_pkg::ADDR_PAIR_DLY: begin
          next_cur.pairDly = {frameData, 4'h0};
          // Auto sync of bank B, timed to strobe fall
          if (cur.syncCtrl[clkdiv_pkg::POS_AUTO_B]) begin
            next_cur.pendB = 1'b1;
          end
        end
        clkdiv_pkg::ADDR_DIV_SEL: begin
          next_cur.divSel = {frameData, 4'h0};
          // Divider load syncs both banks when auto is set
          if (cur.syncCtrl[clkdiv_pkg::POS_AUTO_A] || cur.syncCtrl[clkdiv_pkg::POS_AUTO_B]) begin
            next_cur.pendA = 1'b1;
            next_cur.pendB = 1'b1;
          end
        end
        clkdiv_pkg::ADDR_LOCK: begin
          next_cur.lockReg = {frameData, 4'h0};
        end
        default: begin
          next_cur.frame = cur.frame;
        end
      endcase
    end
    // External or toggle sync events; set wins over the clear above
    if (syncEdge[0]) begin
      next_cur.pendA = 1'b1;
    end
    if (syncEdge[1]) begin
      next_cur.pendB = 1'b1;
    end
    // Hold while sync level active, or one cycle when a pending sync is taken
    next_cur.bankHold[0] = pinActive[0] | (cur.pendA & ~cur.bankHold[0]);
    next_cur.bankHold[1] = pinActive[1] | (cur.pendB & ~cur.bankHold[1]);
    // Groups record alignment; masking later keeps it
    for (int g = 0; g < 4; g++) begin
      if ((g < 3 ? groupHold[g] : groupHold[3]) && !mask[g]) begin
        next_cur.aligned[g] = 1'b1;
      end
    end
  end

  // Register update
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cur <= '0;
      cur.syncCtrl <= clkdiv_pkg::RST_SYNC_CTRL;
      cur.pairDly <= clkdiv_pkg::RST_PAIR_DLY;
      cur.divSel <= clkdiv_pkg::RST_DIV_SEL;
      cur.lockReg <= clkdiv_pkg::RST_LOCK;
    end else begin
      cur <= next_cur;
    end
  end

  // Masked groups ignore sync entirely
  assign groupHold[0] = cur.bankHold[0] & ~mask[0];
  assign groupHold[1] = cur.bankHold[0] & ~mask[1];
  assign groupHold[2] = cur.bankHold[0] & ~mask[2];
  assign groupHold[3] = cur.bankHold[1] & ~mask[3];

  // Bank A group dividers, code 0 divides by eight
  for (genvar g = 0; g < 3; g++) begin : gen_grp
    logic grpClk;
    assign grpDiv[g] = cur.divSel[clkdiv_pkg::POS_DIV0_LO + 3 * g +: 3];
    out_divider #(.W(4)) u_div (
      .core_clk(core_clk),
      .rst(rst),
      .tick(tickA),
      .divide((grpDiv[g] == 3'h0) ? 4'h8 : {1'b0, grpDiv[g]}),
      .hold(groupHold[g]),
      .startDelay(4'h0),
      .halfShift(1'b0),
      .clkOut(grpClk)
    );
    // No digital delay on bank A groups
    assign bankAOut[4*g +: 4] = {4{grpClk}};
  end

  // Pair divider, one instance drives both outputs together
  logic pairClk;
  out_divider #(.W(11)) u_pair (
    .core_clk(core_clk),
    .rst(rst),
    .tick(tickB),
    .divide((pairDiv == 11'h000) ? 11'h001 : pairDiv),
    .hold(groupHold[3]),
    .startDelay({1'b0, cur.appliedDelay}),
    .halfShift(cur.syncCtrl[clkdiv_pkg::POS_HALF_SHIFT]),
    .clkOut(pairClk)
  );
  assign pairOut = {2{pairClk}};

  // Extended mode from delay code or divide, never from half shift
  assign pairExtendedMode = (ddlyCode >= clkdiv_pkg::DDLY_EXT_CODE) ||
                            (pairDiv >= clkdiv_pkg::PDIV_EXT_CODE);
  // Analog delay routing and powerdown
  assign analogDelayRoute = {cur.divSel[clkdiv_pkg::POS_ADLY13], cur.divSel[clkdiv_pkg::POS_ADLY12]};
  assign analogDelayPower = |analogDelayRoute;
  assign pairDelayCycles = cur.appliedDelay;
  assign registersLocked = cur.lockReg[clkdiv_pkg::POS_LOCK];

  // Locked writes leave the delay register unchanged
  locked_write_a: assert property (@(posedge core_clk) disable iff (rst)
    (loadDone && cur.lockReg[clkdiv_pkg::POS_LOCK] && frameAddr == clkdiv_pkg::ADDR_PAIR_DLY)
    |=> $stable(cur.pairDly)) else $error("locked write changed register");
  // Masked pair group never holds
  mask_pair_a: assert property (@(posedge core_clk) disable iff (rst)
    mask[3] |-> !groupHold[3]) else $error("masked pair held");
  // Extended mode follows delay code
  ext_delay_a: assert property (@(posedge core_clk) disable iff (rst)
    (ddlyCode >= 10'd13) |-> pairExtendedMode) else $error("extended mode missing");
  // Analog block powered only when selected
  adly_power_a: assert property (@(posedge core_clk) disable iff (rst)
    analogDelayPower == (cur.divSel[13] | cur.divSel[14])) else $error("analog power wrong");
  // Auto sync on delay load raises bank B pending
  auto_sync_a: assert property (@(posedge core_clk) disable iff (rst)
    (loadDone && writeOk && frameAddr == clkdiv_pkg::ADDR_PAIR_DLY
     && cur.syncCtrl[clkdiv_pkg::POS_AUTO_B]) |=> cur.pendB) else $error("no auto sync");
  // Held pair group output stays low
  hold_low_a: assert property (@(posedge core_clk) disable iff (rst)
    groupHold[3] |=> !pairOut[0]) else $error("pair not low in sync");
  // Pair outputs identical
  pair_same_a: assert property (@(posedge core_clk) disable iff (rst)
    pairOut[0] == pairOut[1]) else $error("pair outputs differ");
  // Delay cycle mapping for short codes
  delay_map_a: assert property (@(posedge core_clk) disable iff (rst)
    (ddlyCode <= 10'd5 && pairDiv == 11'd1) |-> ddlyCycles == 10'd5) else $error("delay map");
endmodule

// ---- sim/serial_host_model.sv ----
// Host model that shifts frames into the block over the three-wire serial link
`timescale 1ns/10ps
module serial_host_model (
  input wire logic core_clk,
  output logic serialClock,
  output logic serialData,
  output logic serial_load_strobe
);
  logic busy = 1'b0; // High while a frame is on the link
  // Link idles with clock and strobe low
  initial begin
    serialClock = 1'b0;
    serialData = 1'b0;
    serial_load_strobe = 1'b0;
  end
  // Data line is not held between frames, so toggle it and let no stale bit look valid
  always @(posedge core_clk) begin
    if (!busy) begin
      serialData <= ~serialData;
    end
  end
  // Shift a frame MSB first with eight core cycles high and nine low per clock, then pulse the strobe
  task automatic send(input logic [31:0] frame);
    busy = 1'b1;
    for (int i = 31; i >= 0; i--) begin
      @(posedge core_clk);
      serialData <= frame[i];
      repeat (8) @(posedge core_clk);
      serialClock <= 1'b1;
      repeat (8) @(posedge core_clk);
      serialClock <= 1'b0;
    end
    repeat (8) @(posedge core_clk);
    serial_load_strobe <= 1'b1;
    repeat (8) @(posedge core_clk);
    serial_load_strobe <= 1'b0;
    busy = 1'b0;
  endtask
endmodule

// ---- sim/clock_divider_sync_control_tb_top.sv ----
// Testbench: programs the divider control over the serial link and checks its outputs
`timescale 1ns/10ps
`define CHK(g, e, m) begin \
  samplesChecked++; \
  if ((g) !== (e)) begin \
    failCount++; \
    $display("wrong value at %0t: %s", $time, m); \
  end \
end
module clock_divider_sync_control_tb_top;
  localparam logic [31:0] AUTO_BOTH = 32'h0600_0000; // Auto sync for both banks
  localparam int HALF_IN = 5; // Core cycles per half input-clock period
  logic core_clk = 1'b0; // Core clock
  logic rst = 1'b1; // Synchronous reset
  logic serialClock;
  logic serialData;
  logic serial_load_strobe;
  logic bank_a_sync_pin = 1'b0; // Sync pins idle low, active high after reset
  logic bank_b_sync_pin = 1'b0;
  logic bank_a_input_clock = 1'b0;
  logic bank_b_input_clock = 1'b0;
  logic [11:0] bankAOut;
  logic [1:0] pairOut;
  logic pairExtendedMode;
  logic analogDelayPower;
  logic [1:0] analogDelayRoute;
  logic [9:0] pairDelayCycles;
  logic registersLocked;
  int failCount = 0; // Mismatches seen
  int samplesChecked = 0; // Comparisons made
  int tick = 0; // Core cycles within half an input period
  int hi;
  int lo;
  int highs;
  int s2[4][3] = '{'{0, 25, 0}, '{1, 26, 1}, '{2, 1045, 1}, '{3, 3, 0}};
  int s3[4][4] = '{'{1, 5, 5, 0}, '{1, 12, 12, 0}, '{3, 0, 6, 0}, '{3, 13, 14, 1}};
  // Core clock, 8 ns period
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  // Both bank input clocks toggle every HALF_IN core cycles
  always @(posedge core_clk) begin
    if (tick == HALF_IN - 1) begin
      tick <= 0;
      bank_a_input_clock <= ~bank_a_input_clock;
      bank_b_input_clock <= ~bank_b_input_clock;
    end else begin
      tick <= tick + 1;
    end
  end
  serial_host_model serial_host_model_i (
    .core_clk(core_clk),
    .serialClock(serialClock),
    .serialData(serialData),
    .serial_load_strobe(serial_load_strobe)
  );
  clock_divider_sync_control clock_divider_sync_control_i (
    .core_clk(core_clk),
    .rst(rst),
    .serialClock(serialClock),
    .serialData(serialData),
    .serial_load_strobe(serial_load_strobe),
    .bank_a_sync_pin(bank_a_sync_pin),
    .bank_b_sync_pin(bank_b_sync_pin),
    .bank_a_input_clock(bank_a_input_clock),
    .bank_b_input_clock(bank_b_input_clock),
    .bankAOut(bankAOut),
    .pairOut(pairOut),
    .pairExtendedMode(pairExtendedMode),
    .analogDelayPower(analogDelayPower),
    .analogDelayRoute(analogDelayRoute),
    .pairDelayCycles(pairDelayCycles),
    .registersLocked(registersLocked)
  );
  // Divider register word from group codes, analog select and pair divide
  function automatic logic [31:0] divWord(logic [2:0] g0, logic [2:0] g1, logic [1:0] sel,
                                          logic [10:0] pdiv);
    return (32'(pdiv) << clkdiv_pkg::POS_PDIV_LO) | (32'(sel) << clkdiv_pkg::POS_ADLY12)
      | (32'(g1) << clkdiv_pkg::POS_DIV1_LO) | (32'(g0) << clkdiv_pkg::POS_DIV0_LO);
  endfunction
  // Register write: one frame, then time for the load to land
  task automatic wr(input logic [3:0] addr, input logic [31:0] data);
    serial_host_model_i.send({data[31:4], addr});
    repeat (8) @(posedge core_clk);
  endtask
  // One output line by index: 0-11 bank A, 12-13 the pair
  function automatic logic pick(int idx);
    return idx < 12 ? bankAOut[idx] : pairOut[idx - 12];
  endfunction
  // High and low time of one output in core cycles, bounded waits
  task automatic meas(input int idx, output int h, output int l);
    int c[4];
    for (int p = 0; p < 4; p++) begin
      c[p] = 0;
      while (pick(idx) === (p % 2 == 0) && c[p] < 2000) begin
        @(posedge core_clk);
        c[p]++;
      end
    end
    h = c[2];
    l = c[3];
  endtask
  // Counts and verdict, then end of run
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Watchdog against a hung run
  initial begin
    repeat (40000) @(posedge core_clk);
    failCount++;
    conclude();
  end
  // Test sequence
  initial begin
    repeat (5) @(posedge core_clk);
    `CHK(bankAOut, 12'h000, "outputs in reset")
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    `CHK(registersLocked, 1'b0, "lock after reset")
    `CHK(analogDelayPower, 1'b0, "analog power after reset")
    `CHK(pairExtendedMode, 1'b0, "mode after reset")
    $display("test reset finished");
    // Analog routing and pair divide power mode
    for (int i = 0; i < 4; i++) begin
      wr(clkdiv_pkg::ADDR_DIV_SEL, divWord(3'h1, 3'h1, 2'(s2[i][0]), 11'(s2[i][1])));
      `CHK(analogDelayRoute, 2'(s2[i][0]), "analog route")
      `CHK(analogDelayPower, 1'(s2[i][0] != 0), "analog power")
      `CHK(pairExtendedMode, 1'(s2[i][2]), "divide power mode")
    end
    $display("test routing finished");
    // Delay latched by auto sync on each load
    wr(clkdiv_pkg::ADDR_SYNC_CTRL, AUTO_BOTH);
    for (int i = 0; i < 4; i++) begin
      wr(clkdiv_pkg::ADDR_DIV_SEL, divWord(3'h1, 3'h1, 2'h0, 11'(s3[i][0])));
      wr(clkdiv_pkg::ADDR_PAIR_DLY, 32'(s3[i][1]) << clkdiv_pkg::POS_DDLY_LO);
      `CHK(pairDelayCycles, 10'(s3[i][2]), "delay cycles")
      `CHK(pairExtendedMode, 1'(s3[i][3]), "delay power mode")
    end
    // Masked pair leaves a new delay unused
    wr(clkdiv_pkg::ADDR_SYNC_CTRL, AUTO_BOTH | 32'h0008_0000);
    wr(clkdiv_pkg::ADDR_PAIR_DLY, 32'h0000_0140);
    `CHK(pairDelayCycles, 10'h00E, "masked delay")
    `CHK(pairExtendedMode, 1'b1, "large delay mode")
    $display("test auto delay finished");
    // Manual sync through a polarity toggle
    wr(clkdiv_pkg::ADDR_SYNC_CTRL, 32'h0000_0000);
    wr(clkdiv_pkg::ADDR_PAIR_DLY, 32'h0000_0070);
    `CHK(pairDelayCycles, 10'h00E, "no sync without auto")
    wr(clkdiv_pkg::ADDR_SYNC_CTRL, 32'h0000_8000);
    `CHK(pairOut, 2'h0, "inverted sync holds pair low")
    wr(clkdiv_pkg::ADDR_SYNC_CTRL, 32'h0000_0000);
    `CHK(pairDelayCycles, 10'h008, "toggle applies delay")
    $display("test polarity toggle finished");
    // Divider periods and duty; marked pair divide synced by the auto load
    wr(clkdiv_pkg::ADDR_SYNC_CTRL, AUTO_BOTH);
    wr(clkdiv_pkg::ADDR_DIV_SEL, divWord(3'h3, 3'h0, 2'h0, 11'h005));
    meas(0, hi, lo);
    `CHK(hi, 3 * HALF_IN, "odd divide high")
    `CHK(lo, 3 * HALF_IN, "odd divide low")
    meas(4, hi, lo);
    `CHK(hi + lo, 16 * HALF_IN, "code zero divides by eight")
    meas(12, hi, lo);
    `CHK(hi, 5 * HALF_IN, "pair high")
    `CHK(lo, 5 * HALF_IN, "pair low")
    `CHK(pairOut[1], pairOut[0], "pair outputs aligned")
    $display("test dividers finished");
    // Held sync with group 0 masked and bank B qualified
    wr(clkdiv_pkg::ADDR_SYNC_CTRL, AUTO_BOTH | 32'h0101_0800);
    bank_a_sync_pin <= 1'b1;
    bank_b_sync_pin <= 1'b1;
    repeat (60) @(posedge core_clk);
    highs = 0;
    for (int i = 0; i < 40; i++) begin
      @(posedge core_clk);
      highs += int'(bankAOut[0]);
      `CHK(bankAOut[11:4], 8'h00, "synced groups low")
      `CHK(pairOut, 2'h0, "qualified pair low")
    end
    `CHK(highs > 0 && highs < 40, 1'b1, "masked group running")
    bank_a_sync_pin <= 1'b0;
    bank_b_sync_pin <= 1'b0;
    $display("test held sync finished");
    // Write lock, then an unmapped address
    wr(clkdiv_pkg::ADDR_LOCK, 32'h0000_0010);
    `CHK(registersLocked, 1'b1, "lock set")
    wr(clkdiv_pkg::ADDR_DIV_SEL, divWord(3'h3, 3'h0, 2'h3, 11'h005));
    `CHK(analogDelayRoute, 2'h0, "locked write ignored")
    wr(clkdiv_pkg::ADDR_PAIR_DLY, 32'h0000_0140);
    `CHK(pairExtendedMode, 1'b0, "locked delay write ignored")
    wr(clkdiv_pkg::ADDR_LOCK, 32'h0000_0000);
    `CHK(registersLocked, 1'b0, "lock cleared")
    wr(4'h9, divWord(3'h3, 3'h0, 2'h3, 11'h005));
    `CHK(analogDelayRoute, 2'h0, "unmapped write ignored")
    wr(clkdiv_pkg::ADDR_DIV_SEL, divWord(3'h3, 3'h0, 2'h3, 11'h005));
    `CHK(analogDelayRoute, 2'h3, "write after unlock")
    $display("test lock finished");
    conclude();
  end
endmodule
